// File: src/sdm_pkg.sv
// Functional notes
// - four-level return store for program counter values, invisible to code
// - active level chosen by a hidden stack_index, never readable or writable
// - call or interrupt acknowledge pushes pc; return reloads newest level
// - reset makes stack_index designate the top of the return store
// - stack full: keep interrupt request pending, acknowledge after a return
// - call on a full stack drops the oldest address, keeps newest four
// - 96 general-purpose bytes at 20H to 7FH, readable and writable
// - unassigned special-function locations below 20H read as zero
// - indirect_port_zero at 00H, indirect_port_one at 02H act via pointers
// - pointer_zero at 01H, pointer_one at 03H reach every bank 0 data location except the indirect ports
// - bank_select 04H, accumulator 05H, program counter low byte 06H
// - table_low_pointer 07H, table_page_pointer 1FH, table_result_high 08H
// - status 0AH, interrupt_control 0BH, watchdog_setting 09H
// - timer high 0FH, timer low 10H, timer_control 11H
// - port data 12H and 14H, direction registers 13H and 15H
// - usb_ps2_status_control 1AH, endpoint_interrupt_status 1BH, clock 1CH
// - arithmetic and rotate work directly on any data location
// - single-bit set and clear on every bit except dedicated bits
// - bank 1 usb registers reached only via pointer_one with bank_select 1
// - table bits 10..8 are 7 on a last-page read, else table_page_pointer when enabled, else pc
package sdm_pkg;
  localparam int PC_WIDTH = 11;
  localparam int STACK_DEPTH = 4;
  localparam int RAM_DEPTH = 96;
  localparam logic [6:0] ADDR_IND_A = 7'h00;
  localparam logic [6:0] ADDR_PTR_A = 7'h01;
  localparam logic [6:0] ADDR_IND_B = 7'h02;
  localparam logic [6:0] ADDR_PTR_B = 7'h03;
  localparam logic [6:0] ADDR_BANK = 7'h04;
  localparam logic [6:0] ADDR_TBL_LOW = 7'h07;
  localparam logic [6:0] ADDR_TBL_HIGH = 7'h08;
  localparam logic [6:0] ADDR_TBL_PAGE = 7'h1F;
  localparam logic [6:0] RAM_BASE = 7'h20;
  // one bit per address below 20H served by the outside peripherals:
  // 05 acc, 06 pc low, 09 watchdog, 0A status, 0B int ctrl, 0F/10/11 timer,
  // 12..15 ports, 1A/1B usb, 1C clock control
  localparam logic [31:0] EXT_MAP = 32'h1C3F_8E60;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam int ROM_HI_LSB = 8;
endpackage

// File: src/sdm_ret_stack.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_ret_stack
  import sdm_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int PC_W = PC_WIDTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [PC_W-1:0] pc_i,
  output logic [PC_W-1:0] top_o,
  output logic full_o,
  output logic empty_o
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [IW:0] FULL_CNT = (IW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] slot;
    logic [IW-1:0] idx;
    logic [IW:0] cnt;
  } sdm_stk_s;
  sdm_stk_s st, next_st;
  logic [IW-1:0] top_idx;

  // index names the next free slot; the newest entry sits just below it
  assign top_idx = st.idx - 1'b1;
  assign top_o = st.slot[top_idx];
  assign full_o = (st.cnt == FULL_CNT);
  assign empty_o = (st.cnt == '0);

  // power-of-two depth makes the index wrap by itself on overflow
  always_comb begin
    next_st = st;
    if (push_i && pop_i) begin
      next_st.slot[top_idx] = pc_i; // return then call: reuse the level
    end else if (push_i) begin
      next_st.slot[st.idx] = pc_i;
      next_st.idx = st.idx + 1'b1;
      if (st.cnt != FULL_CNT) begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end else if (pop_i) begin
      next_st.idx = top_idx;
      if (st.cnt != '0) begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
  end

  // index and slots are private, no data-space path reaches them
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  stk_reset_a: assert property (!reset_i && $past(reset_i) |-> empty_o)
    else $error("stack not empty after reset");
  stk_push_a: assert property (push_i && !pop_i |=> top_o == $past(pc_i))
    else $error("pushed pc not on top");
  stk_full_a: assert property (push_i && !pop_i && full_o |=> full_o)
    else $error("overflow call lost full state");
  sequence two_pushes_pop;
    (push_i && !pop_i) ##1 (push_i && !pop_i) ##1 (pop_i && !push_i);
  endsequence
  stk_lifo_a: assert property (two_pushes_pop |=> top_o == $past(pc_i, 3))
    else $error("return order not last-in first-out");
endmodule
`default_nettype wire

// File: src/sdm_gp_ram.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_gp_ram
  import sdm_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [6:0] idx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } sdm_ram_s;
  sdm_ram_s st, next_st;

  // out-of-range index reads zero instead of an undefined entry
  assign rdata_o = (idx_i < 7'(DEPTH)) ? st.mem[idx_i] : 8'h00;

  // whole-byte write; bit and alu updates are merged by the caller
  always_comb begin
    next_st = st;
    for (int i = 0; i < DEPTH; i++) begin
      if (we_i && idx_i == 7'(i)) begin
        next_st.mem[i] = wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// File: src/sdm_stack_data_map.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_stack_data_map
  import sdm_pkg::*;
#(
  parameter int PC_W = PC_WIDTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [6:0] dm_addr_i,
  input wire logic dm_rd_i,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_wdata_i,
  input wire logic dm_bit_i,
  input wire logic dm_bit_val_i,
  input wire logic [2:0] dm_bit_sel_i,
  output logic [7:0] dm_rdata_o,
  output logic dm_valid_o,
  input wire logic [7:0] ext_rdata_i,
  output logic ext_rd_o,
  output logic ext_wr_o,
  output logic ext_bit_o,
  output logic ext_bit_val_o,
  output logic [2:0] ext_bit_sel_o,
  output logic [6:0] ext_addr_o,
  output logic ext_bank1_o,
  output logic [7:0] ext_wdata_o,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic call_i,
  input wire logic ret_i,
  input wire logic irq_req_i,
  input wire logic irq_en_i,
  output logic irq_ack_o,
  output logic irq_pend_o,
  output logic [PC_W-1:0] ret_pc_o,
  output logic ret_valid_o,
  input wire logic tbl_rd_i,
  input wire logic tbl_last_i,
  input wire logic page_opt_i,
  input wire logic rom_valid_i,
  input wire logic [13:0] rom_data_i,
  output logic [PC_W-1:0] tbl_addr_o,
  output logic tbl_req_o
);
  typedef enum logic [1:0] {CLS_NULL, CLS_RAM, CLS_LOCAL, CLS_EXT} sdm_cls_e;

  typedef struct packed {
    logic [7:0] ptr_a;
    logic [7:0] ptr_b;
    logic [7:0] bank;
    logic [7:0] tbl_low;
    logic [7:0] tbl_page;
    logic [7:0] tbl_high;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_pend;
    logic ext_rd;
    logic ext_wr;
    logic ext_bit;
    logic bit_val;
    logic [2:0] bit_sel;
    logic [6:0] ext_addr;
    logic bank1;
    logic [7:0] ext_wdata;
    logic irq_pend;
    logic irq_ack;
    logic [PC_W-1:0] ret_pc;
    logic ret_valid;
    logic [PC_W-1:0] tbl_addr;
    logic tbl_req;
  } sdm_main_s;

  sdm_main_s st, next_st;
  sdm_cls_e cls;
  logic [6:0] tgt;
  logic tgt_b1;
  logic ind;
  logic self_ref;
  logic loc_hit;
  logic [7:0] loc_rd;
  logic [7:0] old_val;
  logic [7:0] wval;
  logic wr_any;
  logic ram_we;
  logic [6:0] ram_idx;
  logic [7:0] ram_rdata;
  logic stk_full;
  logic stk_empty;
  logic [PC_W-1:0] stk_top;
  logic ack_now;
  logic push;
  logic [2:0] tbl_hi;

  // indirect ports follow the pointers; only pointer_one sees bank 1
  always_comb begin
    tgt = dm_addr_i;
    tgt_b1 = 1'b0;
    ind = 1'b0;
    if (dm_addr_i == ADDR_IND_A) begin
      tgt = st.ptr_a[6:0];
      ind = 1'b1;
    end else if (dm_addr_i == ADDR_IND_B) begin
      tgt = st.ptr_b[6:0];
      // bank 1 only exists above the special area; below it acts as bank 0
      tgt_b1 = st.bank[0] && (st.ptr_b[6:0] >= RAM_BASE);
      ind = 1'b1;
    end
  end

  // a pointer aimed at an indirect port would loop, so it is a null access
  assign self_ref = ind && (tgt == ADDR_IND_A || tgt == ADDR_IND_B);
  assign loc_hit = (tgt == ADDR_PTR_A) || (tgt == ADDR_PTR_B) ||
                   (tgt == ADDR_BANK) || (tgt == ADDR_TBL_LOW) ||
                   (tgt == ADDR_TBL_HIGH) || (tgt == ADDR_TBL_PAGE);

  // address class; bank 1 above the special area belongs to the usb block
  always_comb begin
    if (self_ref) begin
      cls = CLS_NULL;
    end else if (tgt >= RAM_BASE) begin
      cls = tgt_b1 ? CLS_EXT : CLS_RAM;
    end else if (EXT_MAP[tgt[4:0]]) begin
      cls = CLS_EXT;
    end else if (loc_hit) begin
      cls = CLS_LOCAL;
    end else begin
      cls = CLS_NULL;
    end
  end

  // read view of the registers held here
  always_comb begin
    case (tgt)
      ADDR_PTR_A: loc_rd = st.ptr_a;
      ADDR_PTR_B: loc_rd = st.ptr_b;
      ADDR_BANK: loc_rd = st.bank;
      ADDR_TBL_LOW: loc_rd = st.tbl_low;
      ADDR_TBL_HIGH: loc_rd = st.tbl_high;
      ADDR_TBL_PAGE: loc_rd = st.tbl_page;
      default: loc_rd = 8'h00;
    endcase
  end

  // bit updates merge into the old byte so ram and local regs share one path
  always_comb begin
    old_val = (cls == CLS_RAM) ? ram_rdata : loc_rd;
    wval = dm_wdata_i;
    if (!dm_wr_i) begin
      wval = old_val;
      wval[dm_bit_sel_i] = dm_bit_val_i;
    end
  end

  assign wr_any = dm_wr_i || dm_bit_i;
  assign ram_we = wr_any && (cls == CLS_RAM);
  assign ram_idx = tgt - RAM_BASE;

  // interrupt waits while every level is taken; a call has priority
  assign ack_now = st.irq_pend && irq_en_i && !stk_full && !call_i && !ret_i;
  assign push = call_i || ack_now;
  assign tbl_hi = tbl_last_i ? LAST_PAGE :
                  (page_opt_i ? st.tbl_page[2:0] : pc_i[PC_W-1:PC_W-3]);

  // main next-state logic
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.ext_pend = 1'b0;
    next_st.ext_rd = 1'b0;
    next_st.ext_wr = 1'b0;
    next_st.ext_bit = 1'b0;
    next_st.irq_ack = ack_now;
    next_st.ret_valid = ret_i;
    next_st.tbl_req = 1'b0;
    // peripheral data arrives one cycle after its strobe
    if (st.ext_pend) begin
      next_st.rdata = ext_rdata_i;
      next_st.rvalid = 1'b1;
    end
    if (dm_rd_i) begin
      case (cls)
        CLS_RAM: begin
          next_st.rdata = ram_rdata;
          next_st.rvalid = 1'b1;
        end
        CLS_LOCAL: begin
          next_st.rdata = loc_rd;
          next_st.rvalid = 1'b1;
        end
        CLS_EXT: begin
          next_st.ext_rd = 1'b1;
          next_st.ext_pend = 1'b1;
        end
        default: begin
          next_st.rdata = REG_RESET;
          next_st.rvalid = 1'b1;
        end
      endcase
    end
    if (cls == CLS_EXT && (dm_rd_i || wr_any)) begin
      next_st.ext_addr = tgt;
      next_st.bank1 = tgt_b1;
      next_st.ext_wr = dm_wr_i;
      next_st.ext_bit = dm_bit_i && !dm_wr_i;
      next_st.ext_wdata = dm_wdata_i;
      next_st.bit_val = dm_bit_val_i;
      next_st.bit_sel = dm_bit_sel_i;
    end
    // table_result_high is read only, so it refuses writes and bit ops
    if (wr_any && cls == CLS_LOCAL) begin
      case (tgt)
        ADDR_PTR_A: next_st.ptr_a = wval;
        ADDR_PTR_B: next_st.ptr_b = wval;
        ADDR_BANK: next_st.bank = wval;
        ADDR_TBL_LOW: next_st.tbl_low = wval;
        ADDR_TBL_PAGE: next_st.tbl_page = wval;
        default: next_st.tbl_high = st.tbl_high;
      endcase
    end
    if (rom_valid_i) begin
      next_st.tbl_high = {2'b00, rom_data_i[13:ROM_HI_LSB]};
    end
    if (tbl_rd_i) begin
      next_st.tbl_addr = {tbl_hi, st.tbl_low};
      next_st.tbl_req = 1'b1;
    end
    // a new request in the acknowledge cycle is kept, set wins
    next_st.irq_pend = (st.irq_pend && !ack_now) || irq_req_i;
    if (ret_i) begin
      next_st.ret_pc = stk_top;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  sdm_ret_stack #(
    .DEPTH(STACK_DEPTH),
    .PC_W(PC_W)
  ) u_stack (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .push_i(push),
    .pop_i(ret_i),
    .pc_i(pc_i),
    .top_o(stk_top),
    .full_o(stk_full),
    .empty_o(stk_empty)
  );

  sdm_gp_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(ram_we),
    .idx_i(ram_idx),
    .wdata_i(wval),
    .rdata_o(ram_rdata)
  );

  // outputs straight from the state register
  assign dm_rdata_o = st.rdata;
  assign dm_valid_o = st.rvalid;
  assign ext_rd_o = st.ext_rd;
  assign ext_wr_o = st.ext_wr;
  assign ext_bit_o = st.ext_bit;
  assign ext_bit_val_o = st.bit_val;
  assign ext_bit_sel_o = st.bit_sel;
  assign ext_addr_o = st.ext_addr;
  assign ext_bank1_o = st.bank1;
  assign ext_wdata_o = st.ext_wdata;
  assign irq_ack_o = st.irq_ack;
  assign irq_pend_o = st.irq_pend;
  assign ret_pc_o = st.ret_pc;
  assign ret_valid_o = st.ret_valid;
  assign tbl_addr_o = st.tbl_addr;
  assign tbl_req_o = st.tbl_req;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  irq_hold_a: assert property (st.irq_pend && stk_full |=> !irq_ack_o)
    else $error("interrupt acknowledged on full stack");
  irq_serve_a: assert property (ack_now |=> irq_ack_o && stk_top == $past(pc_i))
    else $error("acknowledge did not push pc");
  rsvd_zero_a: assert property (dm_rd_i && !ind && cls == CLS_NULL
    |=> dm_valid_o && dm_rdata_o == 8'h00)
    else $error("reserved location not zero");
  sequence ram_wr_rd;
    (dm_wr_i && !ind && cls == CLS_RAM) ##1
    (dm_rd_i && !wr_any && dm_addr_i == $past(dm_addr_i));
  endsequence
  ram_back_a: assert property (ram_wr_rd |=> dm_rdata_o == $past(dm_wdata_i, 2))
    else $error("ram readback mismatch");
  ptr_write_a: assert property (dm_wr_i && dm_addr_i == ADDR_PTR_A
    |=> st.ptr_a == $past(dm_wdata_i))
    else $error("pointer_zero write lost");
  bank_one_a: assert property (dm_wr_i && dm_addr_i == ADDR_IND_B && st.bank[0]
    && st.ptr_b[6:0] >= RAM_BASE |=> ext_wr_o && ext_bank1_o &&
    ext_addr_o == $past(st.ptr_b[6:0]))
    else $error("bank 1 access misrouted");
  ext_dec_a: assert property (dm_rd_i && !ind && EXT_MAP[dm_addr_i[4:0]] &&
    dm_addr_i < RAM_BASE |=> ext_rd_o ##1 dm_valid_o)
    else $error("peripheral read not forwarded");
  tbl_page_a: assert property (tbl_rd_i && !tbl_last_i && !page_opt_i
    |=> tbl_req_o && tbl_addr_o[10:8] == $past(pc_i[10:8]))
    else $error("table page not from pc");
  tbl_opt_a: assert property (tbl_rd_i && !tbl_last_i && page_opt_i
    |=> tbl_addr_o[10:8] == $past(st.tbl_page[2:0]))
    else $error("table page not from page pointer");
  thigh_ro_a: assert property (wr_any && !ind && dm_addr_i == ADDR_TBL_HIGH
    && !rom_valid_i |=> $stable(st.tbl_high))
    else $error("table_result_high was written");
endmodule
`default_nettype wire

// File: bench/sdm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_core_model
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [6:0] addr_i,
  input wire logic bank1_i,
  input wire logic tbl_req_i,
  input wire logic [10:0] tbl_addr_i,
  output logic [7:0] rdata_o,
  output var logic rom_valid_o,
  output var logic [13:0] rom_data_o
);
  logic [7:0] idle_pat = 8'hA5;

  // a released bus shows a moving pattern, so stale data never matches
  always @(posedge clk_i) begin
    idle_pat <= ~idle_pat;
  end

  // peripheral data encodes bank and address, so a wrong route shows
  assign rdata_o = rd_i ? ({bank1_i, addr_i} ^ 8'h5A) : idle_pat;

  // program store answers a table fetch one cycle after the request
  initial begin
    rom_valid_o = 1'b0;
    rom_data_o = 14'h0000;
  end
  always @(posedge clk_i) begin
    rom_valid_o <= #1 tbl_req_i;
    rom_data_o <= #1 tbl_req_i ? {3'h5, tbl_addr_i} : ~rom_data_o;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdm_pkg::*;
  logic clk_i, reset_i, dm_rd_i, dm_wr_i, dm_bit_i, dm_bit_val_i;
  logic [6:0] dm_addr_i, ext_addr_o;
  logic [7:0] dm_wdata_i, dm_rdata_o, ext_rdata_i, ext_wdata_o;
  logic [2:0] dm_bit_sel_i, ext_bit_sel_o;
  logic dm_valid_o, ext_rd_o, ext_wr_o, ext_bit_o, ext_bit_val_o;
  logic ext_bank1_o, call_i, ret_i, irq_req_i, irq_en_i, irq_ack_o;
  logic irq_pend_o, ret_valid_o, tbl_rd_i, tbl_last_i, page_opt_i;
  logic rom_valid_i, tbl_req_o;
  logic [10:0] pc_i, ret_pc_o, tbl_addr_o;
  logic [13:0] rom_data_i;
  int miscompares, num_checks, ack_cnt;
  int mem[128];
  int stk[$];

  sdm_stack_data_map u_sdm_stack_data_map (.clk_i(clk_i), .reset_i(reset_i),
    .dm_addr_i(dm_addr_i), .dm_rd_i(dm_rd_i), .dm_wr_i(dm_wr_i),
    .dm_wdata_i(dm_wdata_i), .dm_bit_i(dm_bit_i),
    .dm_bit_val_i(dm_bit_val_i), .dm_bit_sel_i(dm_bit_sel_i),
    .dm_rdata_o(dm_rdata_o), .dm_valid_o(dm_valid_o),
    .ext_rdata_i(ext_rdata_i), .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o),
    .ext_bit_o(ext_bit_o), .ext_bit_val_o(ext_bit_val_o),
    .ext_bit_sel_o(ext_bit_sel_o), .ext_addr_o(ext_addr_o),
    .ext_bank1_o(ext_bank1_o), .ext_wdata_o(ext_wdata_o), .pc_i(pc_i),
    .call_i(call_i), .ret_i(ret_i), .irq_req_i(irq_req_i),
    .irq_en_i(irq_en_i), .irq_ack_o(irq_ack_o), .irq_pend_o(irq_pend_o),
    .ret_pc_o(ret_pc_o), .ret_valid_o(ret_valid_o), .tbl_rd_i(tbl_rd_i),
    .tbl_last_i(tbl_last_i), .page_opt_i(page_opt_i),
    .rom_valid_i(rom_valid_i), .rom_data_i(rom_data_i),
    .tbl_addr_o(tbl_addr_o), .tbl_req_o(tbl_req_o));

  sdm_core_model u_sdm_core_model (.clk_i(clk_i), .rd_i(ext_rd_o),
    .addr_i(ext_addr_o), .bank1_i(ext_bank1_o), .tbl_req_i(tbl_req_o),
    .tbl_addr_i(tbl_addr_o), .rdata_o(ext_rdata_i),
    .rom_valid_o(rom_valid_i), .rom_data_o(rom_data_i));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // acknowledges counted mid-cycle, away from the launching edge
  always @(negedge clk_i) begin
    if (irq_ack_o === 1'b1) ack_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // byte write or single-bit write; the model tracks ram only
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic bit_op, input logic [2:0] sel);
    @(posedge clk_i);
    #1;
    dm_addr_i = a;
    dm_wdata_i = d;
    dm_bit_sel_i = sel;
    dm_bit_val_i = d[0];
    dm_wr_i = !bit_op;
    dm_bit_i = bit_op;
    @(posedge clk_i);
    #1;
    dm_wr_i = 1'b0;
    dm_bit_i = 1'b0;
    if (a >= RAM_BASE && !bit_op) mem[a] = d;
    if (a >= RAM_BASE && bit_op) mem[a][sel] = d[0];
  endtask

  // read, wait a bounded time for the answer, compare with expectation
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1;
    dm_addr_i = a;
    dm_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    dm_rd_i = 1'b0;
    for (int i = 0; i < 4 && dm_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(dm_valid_o, 1'b1);
    chk(dm_rdata_o, exp);
  endtask

  // push; the model keeps only the newest four entries
  task automatic call(input logic [10:0] pc);
    @(posedge clk_i);
    #1;
    pc_i = pc;
    call_i = 1'b1;
    @(posedge clk_i);
    #1;
    call_i = 1'b0;
    stk.push_back(pc);
    if (stk.size() > STACK_DEPTH) void'(stk.pop_front());
  endtask

  task automatic ret_chk;
    int e;
    e = stk.pop_back();
    @(posedge clk_i);
    #1;
    ret_i = 1'b1;
    @(posedge clk_i);
    #1;
    ret_i = 1'b0;
    chk(ret_valid_o, 1'b1);
    chk(ret_pc_o, e);
  endtask

  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    logic [7:0] d, pa, lo, pg;
    logic [6:0] a;
    logic [10:0] pc;
    logic [2:0] hi;
    {dm_rd_i, dm_wr_i, dm_bit_i, dm_bit_val_i, call_i, ret_i} = '0;
    {irq_req_i, irq_en_i, tbl_rd_i, tbl_last_i, page_opt_i} = '0;
    {dm_addr_i, dm_wdata_i, dm_bit_sel_i, pc_i} = '0;
    foreach (mem[i]) mem[i] = 0;
    reset_i = 1'b1;
    void'($urandom(53444));
    repeat (8) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk(dm_valid_o, 1'b0);
    chk(irq_pend_o, 1'b0);
    rd(ADDR_PTR_A, 8'h00);
    rd(ADDR_PTR_B, 8'h00);
    rd(ADDR_BANK, 8'h00);
    rd(ADDR_TBL_PAGE, 8'h00);
    // reserved holes read zero; peripheral addresses go to the far side
    for (int i = 5; i < 32; i++) begin
      a = i[6:0];
      if (EXT_MAP[i]) rd(a, {1'b0, a} ^ 8'h5A);
      else if (a != ADDR_TBL_LOW && a != ADDR_TBL_HIGH &&
               a != ADDR_TBL_PAGE) rd(a, 8'h00);
    end
    // ram: both boundaries plus random fill, then read every byte
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 7'h20 : (i == 1) ? 7'h7F : 7'h20 + 7'($urandom % 96);
      wr(a, 8'($urandom), 1'b0, 3'h0);
    end
    for (int i = 32; i < 128; i++) rd(i[6:0], mem[i][7:0]);
    for (int s = 0; s < 8; s++) begin
      a = 7'h20 + 7'($urandom % 96);
      wr(a, 8'($urandom), 1'b1, s[2:0]);
      rd(a, mem[a][7:0]);
    end
    // indirect access through both pointers, then bank 1 routing
    pa = 8'h20 + 8'($urandom % 96);
    d = 8'($urandom);
    wr(ADDR_PTR_A, pa, 1'b0, 3'h0);
    wr(ADDR_IND_A, d, 1'b0, 3'h0);
    mem[pa] = d;
    rd(pa[6:0], d);
    rd(ADDR_IND_A, d);
    pa = 8'h20 + 8'($urandom % 96);
    d = 8'($urandom);
    wr(ADDR_PTR_B, pa, 1'b0, 3'h0);
    wr(ADDR_IND_B, d, 1'b0, 3'h0);
    mem[pa] = d;
    rd(pa[6:0], d);
    wr(ADDR_BANK, 8'h01, 1'b0, 3'h0);
    rd(ADDR_IND_B, {1'b1, pa[6:0]} ^ 8'h5A);
    // bank 1 write and a peripheral bit op show their qualifiers
    wr(ADDR_IND_B, d, 1'b0, 3'h0);
    chk(ext_wr_o, 1'b1);
    chk({ext_bank1_o, ext_addr_o}, {1'b1, pa[6:0]});
    chk(ext_wdata_o, d);
    wr(7'h12, 8'h01, 1'b1, 3'h5);
    chk({ext_bit_o, ext_wr_o}, 2'b10);
    chk({ext_bit_val_o, ext_bit_sel_o}, 4'hD);
    chk({ext_bank1_o, ext_addr_o}, 8'h12);
    wr(ADDR_BANK, 8'h00, 1'b0, 3'h0);
    wr(ADDR_PTR_A, 8'h00, 1'b0, 3'h0);
    rd(ADDR_IND_A, 8'h00);
    // overflow: five pushes keep the newest four, unwound newest first
    for (int i = 0; i < 5; i++) call(11'($urandom));
    for (int i = 0; i < 4; i++) ret_chk();
    // full stack holds back an interrupt until a return frees a level
    for (int i = 0; i < 4; i++) call(11'($urandom));
    @(posedge clk_i);
    #1;
    ack_cnt = 0;
    pc_i = 11'($urandom);
    irq_en_i = 1'b1;
    irq_req_i = 1'b1;
    @(posedge clk_i);
    #1;
    irq_req_i = 1'b0;
    repeat (3) @(posedge clk_i);
    chk(irq_pend_o, 1'b1);
    chk(ack_cnt, 0);
    ret_chk();
    for (int i = 0; i < 4 && ack_cnt == 0; i++) @(negedge clk_i);
    chk(ack_cnt, 1);
    stk.push_back(pc_i);
    irq_en_i = 1'b0;
    for (int i = 0; i < 4; i++) ret_chk();
    // table address in each of the three page modes
    lo = 8'($urandom);
    pg = 8'($urandom);
    wr(ADDR_TBL_LOW, lo, 1'b0, 3'h0);
    wr(ADDR_TBL_PAGE, pg, 1'b0, 3'h0);
    rd(ADDR_TBL_LOW, lo);
    rd(ADDR_TBL_PAGE, pg);
    for (int m = 0; m < 3; m++) begin
      pc = 11'($urandom);
      @(posedge clk_i);
      #1;
      pc_i = pc;
      page_opt_i = (m == 1);
      tbl_last_i = (m == 2);
      tbl_rd_i = 1'b1;
      @(posedge clk_i);
      #1;
      tbl_rd_i = 1'b0;
      hi = (m == 2) ? LAST_PAGE : (m == 1) ? pg[2:0] : pc[10:8];
      chk(tbl_req_o, 1'b1);
      chk(tbl_addr_o, {hi, lo});
      repeat (2) @(posedge clk_i);
      rd(ADDR_TBL_HIGH, {5'h05, hi});
    end
    // result high byte refuses byte and bit writes
    wr(ADDR_TBL_HIGH, 8'hFF, 1'b0, 3'h0);
    wr(ADDR_TBL_HIGH, 8'h01, 1'b1, 3'h7);
    rd(ADDR_TBL_HIGH, {5'h05, hi});
    print_verdict();
  end
endmodule
`default_nettype wire
